// file: verilog/plaus_pkg.sv
// Shared constants for the sine/cosine voltage plausibility monitor
package plaus_pkg;
  localparam int unsigned CLK_HZ             = 200_000_000;
  localparam int unsigned RECOVERY_LONG_MS   = 1000;
  localparam int unsigned RECOVERY_SHORT_MS  = 140;
  localparam int unsigned RECOVERY_LONG_CYC  = (CLK_HZ / 1000) * RECOVERY_LONG_MS;
  localparam int unsigned RECOVERY_SHORT_CYC = (CLK_HZ / 1000) * RECOVERY_SHORT_MS;
  localparam int unsigned REC_CNT_W          = 28;
  localparam int unsigned ADC_W              = 12;
  localparam int unsigned VEC_MIN_DEF        = 800;
  localparam int unsigned VEC_MAX_DEF        = 2400;
  localparam int unsigned MIN_STEP_DEF       = 800;
  localparam int unsigned MIN_DEV_DEF        = 64;
  localparam logic        RELIABLE_RST       = 1'b0;

  typedef enum logic [2:0] {
    ST_UNRELIABLE = 3'b001,
    ST_RECOVER    = 3'b010,
    ST_RELIABLE   = 3'b100
  } rel_state_t;
endpackage : plaus_pkg

// file: verilog/sincos_voltage_plausibility_monitor.sv
// Sine/cosine voltage plausibility monitor with error recovery timing
`timescale 1ns/1ps
// Function
// - While enabled, continuously test sine/cosine voltage relationship.
// - Invalid voltage condition marks the motion reliability bits unreliable.
// - Valid again only after all checks pass uninterrupted for recovery time.
// - Recovery time fixed 1 s in one variant, 0.14 s or 1 s otherwise.
// - Vector length outside tolerance band flags an error.
// - Cosine moved by minimum length: sine must show expected deviation.
// - Sine moved by minimum length: cosine must show expected deviation.
// - Each channel value is positive minus negative input line.
module sincos_voltage_plausibility_monitor #(
  parameter int unsigned W             = plaus_pkg::ADC_W,
  parameter bit          FIXED_VARIANT = 1'b0,
  parameter int unsigned VEC_MIN       = plaus_pkg::VEC_MIN_DEF,
  parameter int unsigned VEC_MAX       = plaus_pkg::VEC_MAX_DEF,
  parameter int unsigned MIN_STEP      = plaus_pkg::MIN_STEP_DEF,
  parameter int unsigned MIN_DEV       = plaus_pkg::MIN_DEV_DEF,
  parameter int unsigned REC_LONG_CYC  = plaus_pkg::RECOVERY_LONG_CYC,
  parameter int unsigned REC_SHORT_CYC = plaus_pkg::RECOVERY_SHORT_CYC
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         monitor_enable,
  input  wire logic         short_recovery_sel,
  input  wire logic         other_checks_ok,
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sin_pos,
  input  wire logic [W-1:0] sin_neg,
  input  wire logic [W-1:0] cos_pos,
  input  wire logic [W-1:0] cos_neg,
  output logic              motion_reliable_r,
  output logic              vector_err_r,
  output logic              deviation_err_r
);
  localparam int unsigned DW = W + 1;
  localparam int unsigned SW = 2 * DW + 1;
  localparam int unsigned CW = plaus_pkg::REC_CNT_W;
  // Squared limits avoid a square root in hardware
  localparam logic [SW-1:0] VMIN_SQ  = SW'(VEC_MIN * VEC_MIN);
  localparam logic [SW-1:0] VMAX_SQ  = SW'(VEC_MAX * VEC_MAX);
  localparam logic [DW:0]   STEP_LIM = (DW+1)'(MIN_STEP);
  localparam logic [DW:0]   DEV_LIM  = (DW+1)'(MIN_DEV);

  function automatic logic [DW:0] abs_diff(input logic signed [DW-1:0] a, input logic signed [DW-1:0] b);
    logic signed [DW:0] d;
    d = (DW+1)'(a) - (DW+1)'(b);
    abs_diff = d[DW] ? (DW+1)'(-d) : (DW+1)'(d);
  endfunction : abs_diff

  logic signed [DW-1:0] sin_d_r;
  logic signed [DW-1:0] cos_d_r;
  logic                 diff_valid_r;
  logic signed [DW-1:0] sin_ref_r;
  logic signed [DW-1:0] cos_ref_r;
  logic                 ref_valid_r;
  logic [CW-1:0]        rec_cnt_r;
  logic [CW-1:0]        rec_limit;
  plaus_pkg::rel_state_t state_r;
  logic [SW-1:0]        mag_sq;
  logic [DW:0]          sin_step;
  logic [DW:0]          cos_step;
  logic                 vec_bad;
  logic                 cos_moved;
  logic                 sin_moved;
  logic                 dev_bad;
  logic                 fail_now;

  // Differential channel values, one cycle after the converter strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sin_d_r      <= '0;
      cos_d_r      <= '0;
      diff_valid_r <= 1'b0;
    end else begin
      diff_valid_r <= sample_valid;
      if (sample_valid) begin
        sin_d_r <= $signed({1'b0, sin_pos}) - $signed({1'b0, sin_neg});
        cos_d_r <= $signed({1'b0, cos_pos}) - $signed({1'b0, cos_neg});
      end
    end
  end

  always_comb begin
    mag_sq    = SW'(sin_d_r) * SW'(sin_d_r) + SW'(cos_d_r) * SW'(cos_d_r);
    vec_bad   = (mag_sq < VMIN_SQ) || (mag_sq > VMAX_SQ);
    sin_step  = abs_diff(sin_d_r, sin_ref_r);
    cos_step  = abs_diff(cos_d_r, cos_ref_r);
    cos_moved = ref_valid_r && (cos_step >= STEP_LIM);
    sin_moved = ref_valid_r && (sin_step >= STEP_LIM);
    dev_bad   = (cos_moved && (sin_step < DEV_LIM))
             || (sin_moved && (cos_step < DEV_LIM));
  end

  // Vector length check per sample
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_err_r <= 1'b0;
    end else if (!monitor_enable) begin
      vector_err_r <= 1'b0;
    end else if (diff_valid_r) begin
      vector_err_r <= vec_bad;
    end
  end

  // Deviation check; reference moves once either channel has travelled far enough
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      deviation_err_r <= 1'b0;
      sin_ref_r       <= '0;
      cos_ref_r       <= '0;
      ref_valid_r     <= 1'b0;
    end else if (!monitor_enable) begin
      deviation_err_r <= 1'b0;
      ref_valid_r     <= 1'b0;
    end else if (diff_valid_r) begin
      deviation_err_r <= dev_bad;
      if (!ref_valid_r || cos_moved || sin_moved) begin
        sin_ref_r   <= sin_d_r;
        cos_ref_r   <= cos_d_r;
        ref_valid_r <= 1'b1;
      end
    end
  end

  // Live select; a change mid-wait only moves the finish line
  assign rec_limit = (!FIXED_VARIANT && short_recovery_sel) ? CW'(REC_SHORT_CYC) : CW'(REC_LONG_CYC);
  assign fail_now  = vector_err_r || deviation_err_r || !other_checks_ok;

  // Reliability state and uninterrupted good time
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r           <= plaus_pkg::ST_UNRELIABLE;
      rec_cnt_r         <= '0;
      motion_reliable_r <= plaus_pkg::RELIABLE_RST;
    end else begin
      case (state_r)
        plaus_pkg::ST_RELIABLE: begin
          if (fail_now) begin
            state_r           <= plaus_pkg::ST_UNRELIABLE;
            motion_reliable_r <= 1'b0;
            rec_cnt_r         <= '0;
          end
        end
        plaus_pkg::ST_UNRELIABLE, plaus_pkg::ST_RECOVER: begin
          if (fail_now) begin
            state_r   <= plaus_pkg::ST_UNRELIABLE;
            rec_cnt_r <= '0;
          end else if (rec_cnt_r >= rec_limit - CW'(1)) begin
            state_r           <= plaus_pkg::ST_RELIABLE;
            motion_reliable_r <= 1'b1;
            rec_cnt_r         <= '0;
          end else begin
            state_r   <= plaus_pkg::ST_RECOVER;
            rec_cnt_r <= rec_cnt_r + CW'(1);
          end
        end
        default: begin
          state_r           <= plaus_pkg::ST_UNRELIABLE;
          motion_reliable_r <= 1'b0;
          rec_cnt_r         <= '0;
        end
      endcase
    end
  end

  a_fail_marks_bad: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fail_now |=> !motion_reliable_r)
    else $error("failure did not mark motion data unreliable");

  a_fail_restarts_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fail_now |=> rec_cnt_r == '0)
    else $error("failure did not restart recovery wait");

  a_rise_after_full: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(motion_reliable_r) |-> $past(rec_cnt_r) >= $past(rec_limit) - CW'(1) && !$past(fail_now))
    else $error("reliable restored before recovery time elapsed");

  a_vector_band: assert property (@(posedge ref_clk) disable iff (!reset_n)
    diff_valid_r && monitor_enable |=> vector_err_r == $past(vec_bad))
    else $error("vector length verdict wrong");

  a_cos_moved_sin: assert property (@(posedge ref_clk) disable iff (!reset_n)
    diff_valid_r && monitor_enable && cos_moved && sin_step < DEV_LIM |=> deviation_err_r)
    else $error("stuck sine not flagged");

  a_sin_moved_cos: assert property (@(posedge ref_clk) disable iff (!reset_n)
    diff_valid_r && monitor_enable && sin_moved && cos_step < DEV_LIM |=> deviation_err_r)
    else $error("stuck cosine not flagged");

  a_diff_values: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sample_valid |=> sin_d_r == $signed({1'b0, $past(sin_pos)}) - $signed({1'b0, $past(sin_neg)})
                  && cos_d_r == $signed({1'b0, $past(cos_pos)}) - $signed({1'b0, $past(cos_neg)}))
    else $error("channel difference wrong");

  a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !monitor_enable |=> !vector_err_r && !deviation_err_r)
    else $error("voltage errors raised while monitoring disabled");

  a_vec_to_bad: assert property (@(posedge ref_clk) disable iff (!reset_n)
    diff_valid_r && monitor_enable && vec_bad |-> ##2 !motion_reliable_r)
    else $error("vector error did not reach reliability bits");

  // Verdicts stand between samples, so a slow converter cannot blink the flags
  a_err_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !diff_valid_r && monitor_enable |=> $stable(vector_err_r) && $stable(deviation_err_r))
    else $error("voltage error changed without a new sample");

  // Good cycles count one by one; a live select change only moves the limit
  a_good_counts_up: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !motion_reliable_r && !fail_now && rec_cnt_r < rec_limit - CW'(1) |=> rec_cnt_r == $past(rec_cnt_r) + CW'(1))
    else $error("recovery wait did not advance");

  // Main scenarios
  c_recovered: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(motion_reliable_r));
  c_vec_fail:  cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(vector_err_r));
  c_dev_fail:  cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(deviation_err_r));
  c_lost:      cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(motion_reliable_r));
  c_restart:   cover property (@(posedge ref_clk) disable iff (!reset_n)
    !motion_reliable_r && rec_cnt_r != '0 && fail_now);
endmodule : sincos_voltage_plausibility_monitor

// file: testbench/sincos_encoder_model.sv
// Analog sine/cosine encoder seen through differential converters
`timescale 1ns/1ps
module sincos_encoder_model (
  input  wire logic        ref_clk,
  output logic             sample_valid,
  output logic [11:0]      sin_pos,
  output logic [11:0]      sin_neg,
  output logic [11:0]      cos_pos,
  output logic [11:0]      cos_neg
);
  initial begin
    sample_valid = 1'b0;
    {sin_pos, sin_neg, cos_pos, cos_neg} = {4{12'h800}};
  end
  // Lines mirror about mid-scale, so a single line alone gives a wrong vector
  task automatic put(input logic signed [11:0] sh, input logic signed [11:0] ch);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    sin_pos <= 12'h800 + sh;
    sin_neg <= 12'h800 - sh;
    cos_pos <= 12'h800 + ch;
    cos_neg <= 12'h800 - ch;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    // Converter output is stale after the strobe; scramble it
    {sin_pos, sin_neg, cos_pos, cos_neg} <= ~{sin_pos, sin_neg, cos_pos, cos_neg};
  endtask : put
endmodule : sincos_encoder_model

// file: testbench/sincos_voltage_plausibility_monitor_tb.sv
// Self-checking bench for the voltage plausibility monitor
`timescale 1ns/1ps
module sincos_voltage_plausibility_monitor_tb;
  logic        ref_clk, reset_n, en, short_sel, oth_ok, sv, rel, verr, derr, rel_fx;
  logic [11:0] sp, sn, cp, cn;
  int          miscompares = 0;
  int          cmp_count = 0;
  sincos_encoder_model u_enc (.ref_clk(ref_clk), .sample_valid(sv), .sin_pos(sp), .sin_neg(sn),
    .cos_pos(cp), .cos_neg(cn));
  // Shortened recovery counts keep the run brief
  sincos_voltage_plausibility_monitor #(.REC_LONG_CYC(100), .REC_SHORT_CYC(14)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .monitor_enable(en), .short_recovery_sel(short_sel),
    .other_checks_ok(oth_ok), .sample_valid(sv), .sin_pos(sp), .sin_neg(sn), .cos_pos(cp),
    .cos_neg(cn), .motion_reliable_r(rel), .vector_err_r(verr), .deviation_err_r(derr));
  // Fixed variant shares all inputs but must ignore the short select
  sincos_voltage_plausibility_monitor #(.FIXED_VARIANT(1'b1), .REC_LONG_CYC(100), .REC_SHORT_CYC(14)) u_dut_fixed (
    .ref_clk(ref_clk), .reset_n(reset_n), .monitor_enable(en), .short_recovery_sel(short_sel),
    .other_checks_ok(oth_ok), .sample_valid(sv), .sin_pos(sp), .sin_neg(sn), .cos_pos(cp),
    .cos_neg(cn), .motion_reliable_r(rel_fx), .vector_err_r(), .deviation_err_r());
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // Bounded wait for the reliable flag; a hang ends the run
  task automatic wait_rel(input int lim, output int n);
    n = 0;
    while (rel !== 1'b1) begin
      cyc(1);
      n++;
      if (n > lim) begin
        miscompares++;
        conclude();
      end
    end
  endtask : wait_rel
  // Sample, then verdict two edges later and reliable one edge after that
  task automatic put_chk(input int sh, input int ch, input logic ve, input logic de);
    u_enc.put(12'(sh), 12'(ch));
    cyc(2);
    chk("vector error", ve, verr);
    chk("deviation error", de, derr);
    cyc(1);
    if (ve || de) chk("reliable after fail", 1'b0, rel);
  endtask : put_chk
  task automatic pulse_fail();
    @(posedge ref_clk);
    oth_ok <= 1'b0;
    @(posedge ref_clk);
    oth_ok <= 1'b1;
    #1;
  endtask : pulse_fail
  task automatic t_vector();
    int n;
    put_chk(100, 100, 1'b1, 1'b0);
    put_chk(1000, 0, 1'b0, 1'b0);
    put_chk(1300, 0, 1'b1, 1'b0);
    put_chk(0, 1000, 1'b0, 1'b0);
    wait_rel(40, n);
  endtask : t_vector
  task automatic t_deviation();
    @(posedge ref_clk);
    en <= 1'b0;
    @(posedge ref_clk);
    en <= 1'b1;
    put_chk(1000, 0, 1'b0, 1'b0);
    put_chk(1000, 400, 1'b0, 1'b1);
    put_chk(0, 1000, 1'b0, 1'b0);
    put_chk(400, 1000, 1'b0, 1'b1);
    put_chk(1000, 0, 1'b0, 1'b0);
  endtask : t_deviation
  task automatic t_disabled();
    @(posedge ref_clk);
    en <= 1'b0;
    put_chk(100, 100, 1'b0, 1'b0);
    put_chk(1000, 0, 1'b0, 1'b0);
    @(posedge ref_clk);
    en <= 1'b1;
  endtask : t_disabled
  // Second failure mid-wait must restart the full count
  task automatic t_recovery();
    int n;
    short_sel <= 1'b0;
    pulse_fail();
    cyc(2);
    chk("reliable after other fail", 1'b0, rel);
    cyc(60);
    chk("reliable mid wait", 1'b0, rel);
    pulse_fail();
    wait_rel(200, n);
    chk("long recovery length", 1'b1, n >= 97 && n <= 103);
    chk("fixed variant reliable", 1'b1, rel_fx);
  endtask : t_recovery
  initial begin
    int n;
    {reset_n, en, short_sel, oth_ok} = 4'h7;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("reliable in reset", 1'b0, rel);
    chk("vector error in reset", 1'b0, verr);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_rel(40, n);
    chk("short recovery length", 1'b1, n >= 12 && n <= 17);
    chk("fixed variant short wait", 1'b0, rel_fx);
    t_vector();
    t_deviation();
    t_disabled();
    t_recovery();
    conclude();
  end
endmodule : sincos_voltage_plausibility_monitor_tb
